// ===== common/field_pwm_defines.svh
// field pwm control: timing counts, duty codes, clock rate.
// assumes a single 100 MHz reference clock; duty is in 1/256 steps.
`ifndef FIELD_PWM_DEFINES_SVH
`define FIELD_PWM_DEFINES_SVH

`define CLK_FREQ_HZ            100000000
`define FIELD_PWM_FREQ_HZ      400
`define PWM_PERIOD_CYC         (`CLK_FREQ_HZ / `FIELD_PWM_FREQ_HZ)
`define PWM_CNT_W              18

`define DUTY_W                 9
`define DUTY_FULL              9'h100
`define MIN_FIELD_DUTY         9'h010
`define FIELD_STROBE_DUTY      9'h030
`define PHASE_KEEP_DUTY        9'h050
`define DUTY_FAST_STEP         9'h004
`define DUTY_SLOW_STEP         9'h001

`define FAULT_PERSIST_TIME_MS  1100
`define FAULT_PERSIST_CYC      (`FAULT_PERSIST_TIME_MS * (`CLK_FREQ_HZ / 1000))

`define RAMP_TIME_FAST_MS      2500
`define RAMP_TIME_SLOW_MS      5000
`define RAMP_STEP_FAST_CYC     (`RAMP_TIME_FAST_MS * (`CLK_FREQ_HZ / 1000) / 256)
`define RAMP_STEP_SLOW_CYC     (`RAMP_TIME_SLOW_MS * (`CLK_FREQ_HZ / 1000) / 256)

`define REG_START_FREQ_AB_HZ   72
`define REG_START_FREQ_C_HZ    122
`define RAMP_DIS_FREQ_AB_HZ    310
`define RAMP_DIS_FREQ_C_HZ     350
`define REG_START_AB_CYC       (`CLK_FREQ_HZ / `REG_START_FREQ_AB_HZ)
`define REG_START_C_CYC        (`CLK_FREQ_HZ / `REG_START_FREQ_C_HZ)
`define RAMP_DIS_AB_CYC        (`CLK_FREQ_HZ / `RAMP_DIS_FREQ_AB_HZ)
`define RAMP_DIS_C_CYC         (`CLK_FREQ_HZ / `RAMP_DIS_FREQ_C_HZ)

`define WAKE_PWM_FREQ_HZ       128
`define WAKE_TOL_PCT           5
`define WAKE_NOM_CYC           (`CLK_FREQ_HZ / `WAKE_PWM_FREQ_HZ)
`define WAKE_MIN_CYC           (`WAKE_NOM_CYC * 100 / (100 + `WAKE_TOL_PCT))
`define WAKE_MAX_CYC           (`WAKE_NOM_CYC * 100 / (100 - `WAKE_TOL_PCT))

`define PERIOD_W               21

`endif

// ===== common/field_pwm_pkg.sv
// field pwm control: shared types.
// assumes field_pwm_defines.svh supplies the widths.
`include "field_pwm_defines.svh"

package field_pwm_pkg;

  typedef logic [`DUTY_W-1:0]   duty_t;
  typedef logic [`PERIOD_W-1:0] period_t;

  typedef enum logic [1:0] {
    MODE_SLEEP    = 2'b00,
    MODE_STROBE   = 2'b01,
    MODE_REGULATE = 2'b10
  } ctrl_state_t;

endpackage : field_pwm_pkg

// ===== common/period_meas_if.sv
// period_meas_if: result of one edge-to-edge period measurement.
// assumes one clock domain shared by meter and consumer.
`timescale 1ns/1ps

interface period_meas_if;
  import field_pwm_pkg::*;
  period_t period;
  logic    fresh;

  modport meter (output period, output fresh);
  modport user  (input  period, input  fresh);
endinterface : period_meas_if

// ===== hdl/period_meter.sv
// period_meter: counts clocks between rising edges of a digital input.
// assumes the input is already synchronous to clk_sys_in.
`timescale 1ns/1ps

module period_meter
  import field_pwm_pkg::*;
(
  // clock and reset
  input  wire logic    clk_sys_in,
  input  wire logic    resetn_in,
  // measured signal
  input  wire logic    sig_in,
  // result
  period_meas_if.meter meas
);

  logic    sig_d_ff;
  period_t cnt_ff;
  period_t period_ff;
  logic    fresh_ff;

  wire rise_w = sig_in & ~sig_d_ff;
  // saturate so a stopped input reads as the slowest frequency
  wire sat_w  = &cnt_ff;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sig_d_ff  <= 1'b0;
      // start saturated: the first edge after reset only starts timing
      cnt_ff    <= '1;
      period_ff <= '1;
      fresh_ff  <= 1'b0;
    end else begin
      sig_d_ff <= sig_in;
      fresh_ff <= rise_w;
      if (rise_w) begin
        period_ff <= cnt_ff;
        cnt_ff    <= period_t'(1);
      end else if (sat_w) begin
        period_ff <= '1;
      end else begin
        cnt_ff <= cnt_ff + period_t'(1);
      end
    end
  end

  assign meas.period = period_ff;
  assign meas.fresh  = fresh_ff;

endmodule : period_meter

// ===== hdl/generator_field_pwm_control.sv
// generator_field_pwm_control: field duty, wake, strobe and fault lamp.
// assumes comparator outputs arrive as clean synchronous levels.
`timescale 1ns/1ps
`include "field_pwm_defines.svh"

module generator_field_pwm_control
  import field_pwm_pkg::*;
#(
  parameter int VARIANT        = 0,
  parameter int FAULT_CYC      = `FAULT_PERSIST_CYC,
  parameter int RAMP_STEP_CYC  = (VARIANT == 1) ? `RAMP_STEP_SLOW_CYC
                                                : `RAMP_STEP_FAST_CYC,
  parameter int PWM_PERIOD_CYC = `PWM_PERIOD_CYC,
  parameter int REG_START_CYC  = (VARIANT == 2) ? `REG_START_C_CYC
                                                : `REG_START_AB_CYC,
  parameter int RAMP_DIS_CYC   = (VARIANT == 2) ? `RAMP_DIS_C_CYC
                                                : `RAMP_DIS_AB_CYC,
  parameter int WAKE_MIN_CYC   = `WAKE_MIN_CYC,
  parameter int WAKE_MAX_CYC   = `WAKE_MAX_CYC
)(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  // generator side comparators
  input  wire logic phase_edge_in,
  input  wire logic phase_present_in,
  input  wire logic sense_below_setpoint_in,
  input  wire logic overvoltage_in,
  // warning terminal, level above turn-on threshold
  input  wire logic warn_pwm_in,
  // outputs
  output logic      field_drive_out,
  output logic      warn_drive_out,
  output logic      awake_out,
  output logic      regulating_out,
  output duty_t     field_duty_out
);

  // ***************************************************************
  // frequency measurement
  // ***************************************************************
  period_meas_if phase_meas ();
  period_meas_if wake_meas ();

  period_meter u_phase_meter (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .sig_in     (phase_edge_in),
    .meas       (phase_meas.meter)
  );

  period_meter u_wake_meter (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .sig_in     (warn_pwm_in),
    .meas       (wake_meas.meter)
  );

  // frequency at or above a limit means period at or below its count (ramp-off: strictly above, strictly below)
  wire reg_start_ok_w =
      phase_meas.period <= period_t'(REG_START_CYC);
  wire ramp_off_w     =
      phase_meas.period < period_t'(RAMP_DIS_CYC);
  wire wake_ok_w      = wake_meas.fresh
                        & (wake_meas.period >= period_t'(WAKE_MIN_CYC))
                        & (wake_meas.period <= period_t'(WAKE_MAX_CYC));

  // ***************************************************************
  // control state
  // ***************************************************************
  ctrl_state_t state_ff;
  ctrl_state_t nxt_state;

  // once awake the unit stays up; pwm loss is ignored
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MODE_SLEEP: begin
        if (wake_ok_w) begin
          nxt_state = MODE_STROBE;
        end
      end
      MODE_STROBE: begin
        if (reg_start_ok_w) begin
          nxt_state = MODE_REGULATE;
        end
      end
      MODE_REGULATE: begin
        nxt_state = MODE_REGULATE;
      end
      default: begin
        nxt_state = MODE_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= MODE_SLEEP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ***************************************************************
  // pwm time base and comparator sampling
  // ***************************************************************
  logic [`PWM_CNT_W-1:0] pwm_cnt_ff;
  logic                  below_ff;

  wire period_end_w = pwm_cnt_ff == `PWM_CNT_W'(PWM_PERIOD_CYC - 1);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pwm_cnt_ff <= '0;
      below_ff   <= 1'b0;
    end else begin
      pwm_cnt_ff <= period_end_w ? '0 : pwm_cnt_ff + `PWM_CNT_W'(1);
      if (period_end_w) begin
        below_ff <= sense_below_setpoint_in;
      end
    end
  end

  // ***************************************************************
  // load response ramp
  // ***************************************************************
  logic [26:0] ramp_cnt_ff;
  logic        ramp_credit_ff;
  duty_t       reg_duty_ff;
  duty_t       nxt_reg_duty;

  wire ramp_tick_w = ramp_cnt_ff == 27'(RAMP_STEP_CYC - 1);
  // falling is four steps per period, rising one per ramp tick (four per period with the ramp off)
  wire duty_t rise_step_w = ramp_off_w ? `DUTY_FAST_STEP
                                       : `DUTY_SLOW_STEP;
  wire rise_ok_w  = ramp_off_w | ramp_credit_ff;
  wire duty_t headroom_w = `DUTY_FULL - reg_duty_ff;

  always_comb begin
    nxt_reg_duty = reg_duty_ff;
    if (state_ff != MODE_REGULATE) begin
      nxt_reg_duty = `FIELD_STROBE_DUTY;
    end else if (period_end_w) begin
      if (below_ff && rise_ok_w) begin
        nxt_reg_duty = (headroom_w < rise_step_w) ? `DUTY_FULL
                       : reg_duty_ff + rise_step_w;
      end else if (!below_ff) begin
        nxt_reg_duty = (reg_duty_ff < `DUTY_FAST_STEP) ? '0
                       : reg_duty_ff - `DUTY_FAST_STEP;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ramp_cnt_ff    <= '0;
      ramp_credit_ff <= 1'b0;
      reg_duty_ff    <= '0;
    end else begin
      ramp_cnt_ff <= ramp_tick_w ? '0 : ramp_cnt_ff + 27'(1);
      // credit is set by the tick and spent by one rising period
      if (ramp_tick_w) begin
        ramp_credit_ff <= 1'b1;
      end else if (period_end_w && below_ff) begin
        ramp_credit_ff <= 1'b0;
      end
      reg_duty_ff <= nxt_reg_duty;
    end
  end

  // ***************************************************************
  // duty selection and field output
  // ***************************************************************
  wire   phase_keep_w = ~phase_present_in & ~sense_below_setpoint_in;
  wire duty_t floor_w = overvoltage_in ? '0 : `MIN_FIELD_DUTY;
  wire duty_t sel_duty_w =
      (state_ff == MODE_SLEEP)  ? '0 :
      (state_ff == MODE_STROBE) ? `FIELD_STROBE_DUTY :
      phase_keep_w            ? `PHASE_KEEP_DUTY   :
      (reg_duty_ff < floor_w) ? floor_w : reg_duty_ff;
  wire duty_t out_duty_w =
      (state_ff == MODE_SLEEP) ? '0 :
      (sel_duty_w < floor_w) ? floor_w : sel_duty_w;

  logic [26:0] on_prod_w;
  assign on_prod_w = 27'(out_duty_w) * 27'(PWM_PERIOD_CYC);
  wire [`PWM_CNT_W-1:0] on_cyc_w = on_prod_w[`PWM_CNT_W+7:8];

  logic  field_ff;
  duty_t duty_ff;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      field_ff <= 1'b0;
      duty_ff  <= '0;
    end else begin
      field_ff <= pwm_cnt_ff < on_cyc_w;
      duty_ff  <= out_duty_w;
    end
  end

  // ***************************************************************
  // fault indication
  // ***************************************************************
  logic [26:0] fault_cnt_ff;
  logic        fault_late_ff;
  logic        warn_ff;

  wire awake_w     = state_ff != MODE_SLEEP;
  wire fault_w     = awake_w & ~phase_present_in
                     & sense_below_setpoint_in;
  wire fault_due_w = fault_cnt_ff == 27'(FAULT_CYC - 1);
  // key-on: lamp lit at once until the engine turns the phase up
  wire keyon_w     = state_ff == MODE_STROBE;

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_cnt_ff  <= '0;
      fault_late_ff <= 1'b0;
      warn_ff       <= 1'b0;
    end else begin
      if (!fault_w) begin
        fault_cnt_ff  <= '0;
        fault_late_ff <= 1'b0;
      end else if (fault_due_w) begin
        fault_late_ff <= 1'b1;
      end else begin
        fault_cnt_ff <= fault_cnt_ff + 27'(1);
      end
      warn_ff <= keyon_w
        | (fault_w & (fault_late_ff | fault_due_w));
    end
  end

  assign field_drive_out = field_ff;
  assign field_duty_out  = duty_ff;
  assign warn_drive_out  = warn_ff;
  assign awake_out       = awake_w;
  assign regulating_out  = state_ff == MODE_REGULATE;

endmodule : generator_field_pwm_control

// ===== verif/pulse_source_model.sv
// pulse_source_model: square wave source for the warning terminal or phase.
// assumes the block samples on rising edges; this side moves on falling.
`timescale 1ns/1ps

module pulse_source_model (
  // clock
  input  wire logic        clk_sys_in,
  // period in clocks, zero holds the line low
  input  wire logic [15:0] period_in,
  // driven line
  output logic             line_out
);
  logic [15:0] cnt_ff;
  initial begin
    cnt_ff = 16'h0;
    line_out = 1'b0;
  end
  // falling-edge updates keep the sampled line settled
  always @(negedge clk_sys_in) begin
    if (period_in == 16'h0) begin
      cnt_ff <= 16'h0;
      line_out <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff >= period_in - 16'h1) ? 16'h0 : cnt_ff + 16'h1;
      line_out <= (cnt_ff < (period_in >> 1));
    end
  end
endmodule : pulse_source_model

// ===== verif/field_pwm_props.sv
// field_pwm_props: port timing checks for the field pwm control.
// assumes it is bound into generator_field_pwm_control with the bench parameters.
`timescale 1ns/1ps

module field_pwm_props
  import field_pwm_pkg::*;
#(
  parameter int FAULT_CYC      = 50,
  parameter int PWM_PERIOD_CYC = 64
)(
  // clock and reset
  input wire logic  clk_sys_in,
  input wire logic  resetn_in,
  // comparators and terminal
  input wire logic  phase_edge_in,
  input wire logic  phase_present_in,
  input wire logic  sense_below_setpoint_in,
  input wire logic  overvoltage_in,
  input wire logic  warn_pwm_in,
  // outputs
  input wire logic  field_drive_out,
  input wire logic  warn_drive_out,
  input wire logic  awake_out,
  input wire logic  regulating_out,
  input wire duty_t field_duty_out
);
  // ******
  // helper counters
  // ******
  logic [15:0] fault_ff;
  logic [15:0] calm_ff;
  logic [15:0] ph_ff;
  logic [3:0]  wake_ff;
  logic        warn_d_ff;
  wire fault = awake_out & ~phase_present_in & sense_below_setpoint_in;
  wire calm  = regulating_out & ~overvoltage_in;
  // field periods are counted from reset release on the one clock
  wire ph_end = ph_ff == 16'(PWM_PERIOD_CYC - 1);
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_ff <= 16'h0;
      calm_ff <= 16'h0;
      ph_ff <= 16'h0;
      wake_ff <= 4'hf;
      warn_d_ff <= 1'b0;
    end else begin
      fault_ff <= fault ? fault_ff + 16'h1 : 16'h0;
      calm_ff <= calm ? calm_ff + {15'h0, ~&calm_ff} : 16'h0;
      ph_ff <= ph_end ? 16'h0 : ph_ff + 16'h1;
      wake_ff <= (warn_pwm_in & ~warn_d_ff) ? 4'h0
                                            : wake_ff + {3'h0, ~&wake_ff};
      warn_d_ff <= warn_pwm_in;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_sleep_quiet: assert property (!awake_out |-> field_duty_out == 9'h000
    && !field_drive_out && !warn_drive_out) else $error("output while asleep");
  a_awake_held: assert property (awake_out |=> awake_out)
    else $error("awake dropped");
  a_wake_cause: assert property ($rose(awake_out) |-> wake_ff <= 4'h3)
    else $error("wake without terminal edge");
  a_strobe_duty: assert property ((awake_out && !regulating_out)[*2]
    |-> field_duty_out == 9'h030) else $error("strobe duty wrong");
  a_keyon_lamp: assert property ((awake_out && !regulating_out)[*2]
    |-> warn_drive_out) else $error("key-on lamp off");
  a_reg_kept: assert property (regulating_out |=> regulating_out
    && awake_out) else $error("regulation dropped");
  a_keep_duty: assert property ((regulating_out && !phase_present_in
    && !sense_below_setpoint_in)[*2] |-> field_duty_out == 9'h050)
    else $error("phase keep duty wrong");
  a_min_floor: assert property (calm_ff > PWM_PERIOD_CYC + 2
    |-> field_duty_out >= 9'h010) else $error("duty under floor");
  a_fault_delay: assert property ($rose(warn_drive_out) && regulating_out
    |-> fault_ff >= FAULT_CYC) else $error("lamp before fault delay");
  a_fault_fire: assert property (fault_ff == FAULT_CYC + 2
    && regulating_out |-> warn_drive_out) else $error("lamp late");
  // a mid-period duty change may legally add an edge, so only the
  // first and last clock of each period are pinned down
  a_pwm_start: assert property (ph_ff == 16'h1
    && 32'(field_duty_out) * PWM_PERIOD_CYC >= 256 |-> field_drive_out)
    else $error("field off at period start");
  a_pwm_end: assert property (ph_ff == 16'h0
    && field_duty_out < 9'h100 |-> !field_drive_out)
    else $error("field on at period end");
endmodule : field_pwm_props

bind generator_field_pwm_control field_pwm_props #(
  .FAULT_CYC      (FAULT_CYC),
  .PWM_PERIOD_CYC (PWM_PERIOD_CYC)
) i_props (
  .clk_sys_in              (clk_sys_in),
  .resetn_in               (resetn_in),
  .phase_edge_in           (phase_edge_in),
  .phase_present_in        (phase_present_in),
  .sense_below_setpoint_in (sense_below_setpoint_in),
  .overvoltage_in          (overvoltage_in),
  .warn_pwm_in             (warn_pwm_in),
  .field_drive_out         (field_drive_out),
  .warn_drive_out          (warn_drive_out),
  .awake_out               (awake_out),
  .regulating_out          (regulating_out),
  .field_duty_out          (field_duty_out)
);

// ===== verif/tb_top.sv
// tb_top: directed scenarios for the field pwm control.
// assumes shortened counts; the wake window is 95..105 clocks.
`timescale 1ns/1ps

module tb_top import field_pwm_pkg::*;;
  localparam int FCYC = 50;
  localparam int PER  = 64;
  logic        clk_sys_in, resetn_in, phase_edge_in, phase_present_in;
  logic        sense_below_setpoint_in, overvoltage_in, warn_pwm_in;
  logic        field_drive_out, warn_drive_out, awake_out, regulating_out;
  duty_t       field_duty_out, d0, d1;
  logic [15:0] ecu_per, ph_per;
  int          err_total, check_count, cyc_cnt, n;

  generator_field_pwm_control #(.FAULT_CYC(FCYC), .RAMP_STEP_CYC(128),
    .PWM_PERIOD_CYC(PER), .REG_START_CYC(300), .RAMP_DIS_CYC(100),
    .WAKE_MIN_CYC(95), .WAKE_MAX_CYC(105)) i_dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .phase_edge_in(phase_edge_in), .phase_present_in(phase_present_in),
    .sense_below_setpoint_in(sense_below_setpoint_in),
    .overvoltage_in(overvoltage_in), .warn_pwm_in(warn_pwm_in),
    .field_drive_out(field_drive_out), .warn_drive_out(warn_drive_out),
    .awake_out(awake_out), .regulating_out(regulating_out),
    .field_duty_out(field_duty_out));
  pulse_source_model i_ecu (.clk_sys_in(clk_sys_in), .period_in(ecu_per),
    .line_out(warn_pwm_in));
  pulse_source_model i_phase (.clk_sys_in(clk_sys_in), .period_in(ph_per),
    .line_out(phase_edge_in));

  // ******
  // checking and closing
  // ******
  task automatic cmp_bit(input string nm, input logic ex, input logic got);
    check_count++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED %s exp %0b got %0b", nm, ex, got);
    end
  endtask : cmp_bit
  task automatic cmp_duty(input string nm, input duty_t ex, input duty_t got);
    check_count++;
    if (got !== ex) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got);
    end
  endtask : cmp_duty
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic wait_cyc(input int c);
    repeat (c) @(negedge clk_sys_in);
  endtask : wait_cyc

  // ******
  // scenarios
  // ******
  task automatic t_wake;
    ecu_per = 16'h50;
    wait_cyc(500);
    cmp_bit("wake off band", 1'b0, awake_out);
    ecu_per = 16'h64;
    for (n = 0; n < 400 && awake_out !== 1'b1; n++) wait_cyc(1);
    cmp_bit("wake", 1'b1, awake_out);
    wait_cyc(5);
    cmp_bit("key-on lamp", 1'b1, warn_drive_out);
    cmp_duty("strobe duty", 9'h030, field_duty_out);
    n = 0;
    repeat (PER) begin
      wait_cyc(1);
      n += field_drive_out;
    end
    cmp_duty("strobe width", 9'h00c, n[8:0]);
    ecu_per = 16'h0;
    $display("test wake done");
  endtask : t_wake
  task automatic t_start;
    ph_per = 16'h190;
    wait_cyc(1500);
    cmp_bit("slow phase", 1'b0, regulating_out);
    ph_per = 16'h0fa;
    for (n = 0; n < 700 && regulating_out !== 1'b1; n++) wait_cyc(1);
    cmp_bit("regulation", 1'b1, regulating_out);
    wait_cyc(3);
    cmp_bit("lamp off", 1'b0, warn_drive_out);
    $display("test start done");
  endtask : t_start
  task automatic t_ramp;
    d0 = field_duty_out;
    wait_cyc(PER * 20);
    d1 = field_duty_out;
    cmp_bit("slow ramp", 1'b1, d1 - d0 >= 9 && d1 - d0 <= 11);
    ph_per = 16'h050;
    wait_cyc(PER * 3);
    d0 = field_duty_out;
    wait_cyc(PER * 10);
    d1 = field_duty_out;
    cmp_bit("ramp off", 1'b1, d1 - d0 >= 36 && d1 - d0 <= 44);
    sense_below_setpoint_in = 1'b0;
    // latched comparator: the next period end still rises once
    wait_cyc(PER + 2);
    d0 = field_duty_out;
    wait_cyc(PER * 5);
    d1 = field_duty_out;
    cmp_bit("fall", 1'b1, d0 - d1 >= 16 && d0 - d1 <= 24);
    $display("test ramp done");
  endtask : t_ramp
  task automatic t_ov;
    overvoltage_in = 1'b1;
    wait_cyc(PER * 40);
    cmp_duty("ov duty", 9'h000, field_duty_out);
    overvoltage_in = 1'b0;
    wait_cyc(PER * 3);
    cmp_duty("floor", 9'h010, field_duty_out);
    phase_present_in = 1'b0;
    wait_cyc(PER * 2);
    cmp_duty("phase keep", 9'h050, field_duty_out);
    $display("test ov done");
  endtask : t_ov
  task automatic t_fault;
    sense_below_setpoint_in = 1'b1;
    wait_cyc(40);
    sense_below_setpoint_in = 1'b0;
    wait_cyc(2);
    sense_below_setpoint_in = 1'b1;
    for (n = 0; n < 200 && warn_drive_out !== 1'b1; n++) wait_cyc(1);
    cmp_bit("fault delay", 1'b1, n >= FCYC && n <= FCYC + 2);
    $display("test fault done");
  endtask : t_fault

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {err_total, check_count, cyc_cnt} = '0;
    {ecu_per, ph_per} = '0;
    resetn_in = 1'b0;
    phase_present_in = 1'b1;
    sense_below_setpoint_in = 1'b1;
    overvoltage_in = 1'b0;
    wait_cyc(6);
    resetn_in = 1'b1;
    t_wake();
    t_start();
    t_ramp();
    t_ov();
    t_fault();
    test_done();
  end
endmodule : tb_top
